// ### inc/eio_defs.svh
// constants for the external i/o trigger and end-of-measurement block
`ifndef EIO_DEFS_SVH
`define EIO_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define EIO_A_CTRL 8'h00
`define EIO_A_TIME 8'h04
`define EIO_A_JDG 8'h08
`define EIO_A_DIG 8'h0c
`define EIO_A_COMMIT 8'h10
`define EIO_A_STAT 8'h14
`define EIO_A_FJ 8'h18
`define EIO_A_FD 8'h1c

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define EIO_TM_EOM_LSB 16
`define EIO_ST_EVT_LSB 16
`define EIO_CTRL_RST 10'h020
`define EIO_FILT_DEF 9'd50
`define EIO_EOM_DEF 7'd5

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define EIO_CLK_NS 50
`define EIO_MS_NS 1000000
`define EIO_FILT_MIN 9'd50
`define EIO_FILT_MAX 9'd500
`define EIO_EOM_MIN 7'd1
`define EIO_EOM_MAX 7'd100
`define EIO_AUTO_MS 9'd5

`endif

// ### inc/eio_pkg.sv
// types for the external i/o trigger and end-of-measurement block
package eio_pkg;

  typedef enum logic [1:0] {
    EOM_IDLE = 2'b00,
    EOM_PULSE = 2'b01,
    EOM_HOLD = 2'b11
  } eio_eom_st_t;

  typedef struct packed {
    logic test;
    logic [1:0] scan;
    logic mux_route;
    logic autocal;
    logic eom_pulse;
    logic acquire_strobe_off;
    logic filt_en;
    logic ext;
    logic bcd;
  } eio_cfg_t;

  typedef struct packed {
    logic acquire_strobe;
    logic low_group_sel;
    logic scan_halt;
    logic scanner_terminal_select;
    logic print_req;
    logic zero_adjust_request;
    logic key_lock;
  } eio_in_t;

  typedef struct packed {
    logic over_input;
    logic [2:0] user_lines;
    logic outside_class_flag;
    logic [9:0] sort_class_flags;
    logic t_fail;
    logic t_pass;
    logic t_err;
    logic lo;
    logic pass;
    logic hi;
    logic index;
    logic err;
  } eio_jdg_t;

  typedef struct packed {
    logic measure_done_flag;
    eio_jdg_t jdg;
    logic combined_verdict;
    logic [15:0] decimal_digit_lines;
    logic [3:0] range_code;
  } eio_pins_t;

endpackage : eio_pkg

// ### design/eio_top.sv
// external i/o port: trigger, filters, result lines and end-of-measurement
// Operation
// - two output modes, verdict or decimal digits; verdict mode after reset
// - verdict mode drives done, error, index, comparator, temperature, classes, user lines
// - lower-group select honoured only in decimal digit mode
// - lower group: digits 1-3 plus range code; else digits 4-7
// - trigger source internal or external; internal after reset
// - scanner routing with auto or step scan forces external source
// - enabled filter passes trigger or print only after 50-500 ms hold
// - external hold timing: done stays until next trigger or zero adjust
// - external pulse timing: done ends after programmed 1-100 ms width
// - internal source: fixed 5 ms pulse with auto calibration, none manual
// - test mode shows every input and forces every output
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "eio_defs.svh"
`default_nettype none

// ---------------------------------------------------------------
// hold timer: done once run has stayed high for ms milliseconds
// ---------------------------------------------------------------
module eio_hold #(
  parameter int unsigned CYC = 20000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic [8:0] ms,
  output logic done
);
  localparam int PW = $clog2(CYC);
  localparam logic [PW-1:0] PMAX = PW'(CYC - 1);
  logic [PW-1:0] pre_q, pre_d;
  logic [8:0] ms_q, ms_d;
  logic done_q, done_d;

  always_comb
  begin
    pre_d = pre_q;
    ms_d = ms_q;
    // restarting on every drop keeps the hold time exact, not tick-quantised
    if (!run)
    begin
      pre_d = '0;
      ms_d = '0;
    end
    else if (ms_q < ms)
    begin
      pre_d = (pre_q == PMAX) ? '0 : pre_q + 1'b1;
      if (pre_q == PMAX)
        ms_d = ms_q + 1'b1;
    end
    done_d = run && (ms_q >= ms);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_q <= '0;
      ms_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      ms_q <= ms_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

  a_hold_full : assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(done_q) |-> $past(run) && $past(ms_q) >= $past(ms))
    else $error("hold timer ended early");
endmodule : eio_hold

// ---------------------------------------------------------------
// top
// ---------------------------------------------------------------
module eio_top #(
  parameter int unsigned MS_CYCLES = `EIO_MS_NS / `EIO_CLK_NS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // port pins
  input wire eio_pkg::eio_in_t ext_in,
  output var eio_pkg::eio_pins_t pins,
  // measurement engine strobes
  output logic meas_start,
  output logic print_go,
  output logic zadj_go
);
  logic [1:0] rs_q;
  logic rst_s_n;
  eio_pkg::eio_in_t in_m_q, in_s_q;
  eio_pkg::eio_cfg_t cfg_q, cfg_d;
  logic [8:0] filt_q, filt_d;
  logic [6:0] ew_q, ew_d;
  eio_pkg::eio_jdg_t jdg_q, jdg_d, rj_q, rj_d;
  logic [31:0] dig_q, dig_d, rdg_q, rdg_d, rd_q, rd_d;
  logic [23:0] fj_q, fj_d;
  logic [20:0] fd_q, fd_d;
  logic [2:0] evt_q, evt_d;
  logic wr_q, wr_d, pub_q, pub_d;
  eio_pkg::eio_eom_st_t st_q, st_d;
  eio_pkg::eio_pins_t pins_q, pins_d;
  logic trg_p_q, prn_p_q, zad_p_q, start_q, prn_q, zad_q;
  logic trg_done, prn_done, eom_done, trg_f, prn_f, trg_e, prn_e, zad_e;
  logic ext_eff, acc, wacc;
  logic [8:0] fv;
  logic [6:0] ev;

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rs_q <= 2'h0;
    else
      rs_q <= {rs_q[0], 1'b1};
  end
  assign rst_s_n = rs_q[1];

  // every controller line passes two flops before use
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      in_m_q <= '0;
      in_s_q <= '0;
    end
    else
    begin
      in_m_q <= ext_in;
      in_s_q <= in_m_q;
    end
  end

  // ---------------------------------------------------------------
  // trigger source, filters and edges
  // ---------------------------------------------------------------
  assign ext_eff = cfg_q.ext || (cfg_q.mux_route && cfg_q.scan != 2'h0);

  eio_hold #(.CYC(MS_CYCLES)) u_trg (
    .clk_sys(clk_sys),
    .rst_n(rst_s_n),
    .run(in_s_q.acquire_strobe && cfg_q.filt_en),
    .ms(filt_q),
    .done(trg_done)
  );
  eio_hold #(.CYC(MS_CYCLES)) u_prn (
    .clk_sys(clk_sys),
    .rst_n(rst_s_n),
    .run(in_s_q.print_req && cfg_q.filt_en),
    .ms(filt_q),
    .done(prn_done)
  );
  eio_hold #(.CYC(MS_CYCLES)) u_eom (
    .clk_sys(clk_sys),
    .rst_n(rst_s_n),
    .run(st_q == eio_pkg::EOM_PULSE),
    .ms(ext_eff ? {2'h0, ew_q} : `EIO_AUTO_MS),
    .done(eom_done)
  );

  always_comb
  begin
    trg_f = in_s_q.acquire_strobe && (!cfg_q.filt_en || trg_done);
    prn_f = in_s_q.print_req && (!cfg_q.filt_en || prn_done);
    trg_e = cfg_q.acquire_strobe_off ? (trg_p_q && !trg_f) : (trg_f && !trg_p_q);
    prn_e = prn_f && !prn_p_q;
    zad_e = in_s_q.zero_adjust_request && !zad_p_q;
  end

  // ---------------------------------------------------------------
  // avalon slave and registers
  // ---------------------------------------------------------------
  always_comb
  begin
    cfg_d = cfg_q;
    filt_d = filt_q;
    ew_d = ew_q;
    jdg_d = jdg_q;
    dig_d = dig_q;
    fj_d = fj_q;
    fd_d = fd_q;
    rd_d = rd_q;
    pub_d = 1'b0;
    evt_d = evt_q;
    rj_d = rj_q;
    rdg_d = rdg_q;
    fv = avs_writedata[8:0];
    ev = avs_writedata[`EIO_TM_EOM_LSB +: 7];
    if (fv < `EIO_FILT_MIN)
      fv = `EIO_FILT_MIN;
    else if (fv > `EIO_FILT_MAX)
      fv = `EIO_FILT_MAX;
    if (ev < `EIO_EOM_MIN)
      ev = `EIO_EOM_MIN;
    else if (ev > `EIO_EOM_MAX)
      ev = `EIO_EOM_MAX;
    // one wait state: data loads on the first edge, stands while wait is low
    acc = (avs_read || avs_write) && !wr_q;
    wacc = acc && avs_write;
    wr_d = !((avs_read || avs_write) && wr_q);
    if (avs_read && wr_q)
    begin
      case (avs_address)
        `EIO_A_CTRL: rd_d = {22'h0, cfg_q};
        `EIO_A_TIME: rd_d = {9'h0, ew_q, 7'h0, filt_q};
        `EIO_A_JDG: rd_d = {9'h0, jdg_q};
        `EIO_A_DIG: rd_d = dig_q;
        `EIO_A_STAT: rd_d = {13'h0, evt_q, 7'h0, pins_q.measure_done_flag, ext_eff, in_s_q};
        `EIO_A_FJ: rd_d = {8'h0, fj_q};
        `EIO_A_FD: rd_d = {11'h0, fd_q};
        default: rd_d = 32'h0;
      endcase
    end
    if (wacc)
    begin
      case (avs_address)
        `EIO_A_CTRL: cfg_d = avs_writedata[9:0];
        `EIO_A_TIME:
        begin
          filt_d = fv;
          ew_d = ev;
        end
        `EIO_A_JDG: jdg_d = avs_writedata[22:0];
        `EIO_A_DIG: dig_d = avs_writedata;
        `EIO_A_COMMIT: pub_d = 1'b1;
        `EIO_A_STAT: evt_d = evt_q & ~avs_writedata[`EIO_ST_EVT_LSB +: 3];
        `EIO_A_FJ: fj_d = avs_writedata[23:0];
        `EIO_A_FD: fd_d = avs_writedata[20:0];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    evt_d = evt_d | {zad_e, prn_e, trg_e};
    if (pub_d)
    begin
      rj_d = jdg_q;
      rdg_d = dig_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      cfg_q <= `EIO_CTRL_RST;
      filt_q <= `EIO_FILT_DEF;
      ew_q <= `EIO_EOM_DEF;
      jdg_q <= '0;
      dig_q <= 32'h0;
      fj_q <= 24'h0;
      fd_q <= 21'h0;
      rd_q <= 32'h0;
      wr_q <= 1'b1;
      pub_q <= 1'b0;
      evt_q <= 3'h0;
      rj_q <= '0;
      rdg_q <= 32'h0;
    end
    else
    begin
      cfg_q <= cfg_d;
      filt_q <= filt_d;
      ew_q <= ew_d;
      jdg_q <= jdg_d;
      dig_q <= dig_d;
      fj_q <= fj_d;
      fd_q <= fd_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      pub_q <= pub_d;
      evt_q <= evt_d;
      rj_q <= rj_d;
      rdg_q <= rdg_d;
    end
  end

  // ---------------------------------------------------------------
  // end of measurement and output lines
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      eio_pkg::EOM_IDLE: st_d = eio_pkg::EOM_IDLE;
      eio_pkg::EOM_PULSE: if (eom_done) st_d = eio_pkg::EOM_IDLE;
      eio_pkg::EOM_HOLD: if (trg_e || zad_e) st_d = eio_pkg::EOM_IDLE;
      default: st_d = eio_pkg::EOM_IDLE;
    endcase
    if (pub_q)
    begin
      if (!ext_eff)
        st_d = cfg_q.autocal ? eio_pkg::EOM_PULSE : eio_pkg::EOM_IDLE;
      else
        st_d = cfg_q.eom_pulse ? eio_pkg::EOM_PULSE : eio_pkg::EOM_HOLD;
    end
    pins_d = '0;
    // done follows state, one edge after the published results reach the pins
    pins_d.measure_done_flag = (st_q != eio_pkg::EOM_IDLE);
    if (cfg_q.bcd)
    begin
      pins_d.jdg.err = rj_q.err;
      pins_d.jdg.pass = rj_q.pass;
      pins_d.combined_verdict = rj_q.hi || rj_q.lo;
      if (in_s_q.low_group_sel)
      begin
        pins_d.decimal_digit_lines = {4'h0, rdg_q[11:0]};
        pins_d.range_code = rdg_q[15:12];
      end
      else
        pins_d.decimal_digit_lines = rdg_q[31:16];
    end
    else
      pins_d.jdg = rj_q;
    if (cfg_q.test)
      pins_d = {fj_q, fd_q};
  end

  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      st_q <= eio_pkg::EOM_IDLE;
      pins_q <= '0;
      trg_p_q <= 1'b0;
      prn_p_q <= 1'b0;
      zad_p_q <= 1'b0;
      start_q <= 1'b0;
      prn_q <= 1'b0;
      zad_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      pins_q <= pins_d;
      trg_p_q <= trg_f;
      prn_p_q <= prn_f;
      zad_p_q <= in_s_q.zero_adjust_request;
      start_q <= trg_e && ext_eff;
      prn_q <= prn_e;
      zad_q <= zad_e;
    end
  end

  assign avs_readdata = rd_q;
  assign avs_waitrequest = wr_q;
  assign pins = pins_q;
  assign meas_start = start_q;
  assign print_go = prn_q;
  assign zadj_go = zad_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_s_n);

  sequence s_publish;
    pub_q && !cfg_q.test;
  endsequence
  sequence s_hold_release;
    st_q == eio_pkg::EOM_HOLD && (trg_e || zad_e) && !pub_q;
  endsequence

  a_done_after_out : assert property ($rose(pins_q.measure_done_flag) && $past(!cfg_q.test)
    |-> $past(pub_q, 2) && $stable(pins_q.jdg.err))
    else $error("done rose without prior result update");
  a_verdict_lines : assert property ($past(!cfg_q.bcd && !cfg_q.test)
    |-> pins_q.jdg == $past(rj_q) && pins_q.decimal_digit_lines == 16'h0)
    else $error("verdict lines wrong");
  a_low_group : assert property ($past(cfg_q.bcd && !cfg_q.test && in_s_q.low_group_sel)
    |-> pins_q.range_code == $past(rdg_q[15:12]))
    else $error("lower digit group wrong");
  a_src_forced : assert property (cfg_q.mux_route && cfg_q.scan != 2'h0 |-> ext_eff)
    else $error("scanner did not force external source");
  a_hold_end : assert property (s_hold_release |=> st_q == eio_pkg::EOM_IDLE
    ##1 !pins_q.measure_done_flag)
    else $error("held done not released");
  a_hold_keep : assert property (st_q == eio_pkg::EOM_HOLD && !trg_e && !zad_e && !pub_q
    |=> st_q == eio_pkg::EOM_HOLD)
    else $error("held done dropped early");
  a_int_manual : assert property (s_publish ##0 (!ext_eff && !cfg_q.autocal)
    |=> st_q == eio_pkg::EOM_IDLE [*2])
    else $error("done under manual calibration");
  a_pulse_end : assert property (st_q == eio_pkg::EOM_PULSE && eom_done && !pub_q
    |=> st_q == eio_pkg::EOM_IDLE)
    else $error("pulse did not end");
  a_test_force : assert property ($past(cfg_q.test) |-> pins_q == $past({fj_q, fd_q}))
    else $error("forced outputs not shown");
  a_acquire_strobe_edge : assert property (trg_f && !trg_p_q && !cfg_q.acquire_strobe_off && ext_eff
    |=> meas_start)
    else $error("trigger edge missed");
  a_bus_wait : assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state too long");
endmodule : eio_top

`default_nettype wire

// ### dv/eio_ctrl_model.sv
// external controller model driving the port input lines
`timescale 1ns/1ps
`default_nettype none
module eio_ctrl_model (
  // clock
  input wire logic clk_sys,
  // port input lines, off while open
  output var eio_pkg::eio_in_t ext_in
);
  initial ext_in = '0;

  // ----------------
  // line control
  // ----------------
  // levels change just after a rising edge, as a plc output would
  task automatic lvl(input int b, input logic v);
    @(posedge clk_sys);
    ext_in[b] <= v;
  endtask : lvl

  // held for n cycles; the filter drops anything shorter than its time
  task automatic pulse(input int b, input int n);
    lvl(b, 1'b1);
    repeat (n) @(posedge clk_sys);
    ext_in[b] <= 1'b0;
  endtask : pulse
endmodule : eio_ctrl_model
`default_nettype wire

// ### dv/eio_top_tb.sv
// self-checking bench for the external i/o block
`timescale 1ns/1ps
`include "eio_defs.svh"
`default_nettype none
module eio_top_tb;
  // short millisecond keeps the filter and pulse runs small
  localparam int MSC = 20;
  logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic meas_start, print_go, zadj_go;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  eio_pkg::eio_in_t ext_in;
  eio_pkg::eio_pins_t pins, snap;
  int num_errors = 0, n_tests = 0, n_ms = 0, n_pr = 0, n_za = 0, len, m, p;

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  eio_top #(.MS_CYCLES(MSC)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_in(ext_in), .pins(pins),
    .meas_start(meas_start), .print_go(print_go), .zadj_go(zadj_go));
  eio_ctrl_model u_ctrl (.clk_sys(clk_sys), .ext_in(ext_in));

  // one-cycle strobes are counted where they stand
  always @(posedge clk_sys)
  begin
    if (meas_start === 1'b1) n_ms <= n_ms + 1;
    if (print_go === 1'b1) n_pr <= n_pr + 1;
    if (zadj_go === 1'b1) n_za <= n_za + 1;
  end

  // ----------------
  // tasks
  // ----------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // an edge passes first so no strobe is assigned twice in one step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_sys);
    // no wait count assumed; only the watchdog ends a hung access
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // snapshot taken on the edge where done is first seen high
  task automatic done_len(input int lim);
    int n;
    n = 0;
    len = 0;
    while (pins.measure_done_flag !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys);
      n++;
    end
    snap = pins;
    while (pins.measure_done_flag === 1'b1 && len < lim)
    begin
      @(posedge clk_sys);
      len++;
    end
  endtask : done_len

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    #(50 * 20000);
    num_errors++;
    print_verdict();
  end

  // ----------------
  // tests
  // ----------------
  initial
  begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdc(`EIO_A_CTRL, 32'h0000_0020);
    rdc(`EIO_A_TIME, 32'h0005_0032);
    rdc(8'h20, 32'h0);
    // internal source: a trigger line edge starts nothing outside
    m = n_ms;
    u_ctrl.pulse(6, 2);
    repeat (8) @(posedge clk_sys);
    chk(n_ms - m, 0);
    // internal source, auto calibration: fixed 5 ms pulse
    bus(1'b1, `EIO_A_JDG, 32'h0055_aa33);
    bus(1'b1, `EIO_A_COMMIT, 32'h0);
    done_len(200);
    chk(snap.jdg, 23'h55aa33);
    chk(len >= 5 * MSC && len <= 5 * MSC + 5, 1'b1);
    bus(1'b1, `EIO_A_CTRL, 32'h0);
    bus(1'b1, `EIO_A_COMMIT, 32'h0);
    done_len(200);
    chk(len, 0);
    // digit mode, both groups
    bus(1'b1, `EIO_A_CTRL, 32'h21);
    bus(1'b1, `EIO_A_DIG, 32'h7654_a321);
    u_ctrl.lvl(5, 1'b1);
    bus(1'b1, `EIO_A_COMMIT, 32'h0);
    done_len(50);
    chk({snap.decimal_digit_lines, snap.range_code}, 20'h0321a);
    u_ctrl.lvl(5, 1'b0);
    repeat (8) @(posedge clk_sys);
    chk({pins.decimal_digit_lines, pins.range_code}, 20'h76540);
    // external hold: trigger, then zero adjust end it
    bus(1'b1, `EIO_A_CTRL, 32'h22);
    bus(1'b1, `EIO_A_COMMIT, 32'h0);
    done_len(300);
    chk(len, 300);
    // group select has no effect in verdict mode
    u_ctrl.lvl(5, 1'b1);
    repeat (8) @(posedge clk_sys);
    chk({pins.decimal_digit_lines, pins.range_code}, 20'h0);
    chk(pins.jdg, 23'h55aa33);
    u_ctrl.lvl(5, 1'b0);
    m = n_ms;
    u_ctrl.pulse(6, 2);
    repeat (8) @(posedge clk_sys);
    chk(pins.measure_done_flag, 1'b0);
    chk(n_ms - m, 1);
    bus(1'b1, `EIO_A_COMMIT, 32'h0);
    done_len(20);
    m = n_za;
    u_ctrl.pulse(1, 2);
    repeat (8) @(posedge clk_sys);
    chk(pins.measure_done_flag, 1'b0);
    chk(n_za - m, 1);
    // external pulse: 2 ms, then width 0 clamped to 1 ms
    bus(1'b1, `EIO_A_TIME, 32'h0002_0032);
    bus(1'b1, `EIO_A_CTRL, 32'h32);
    bus(1'b1, `EIO_A_COMMIT, 32'h0);
    done_len(50);
    chk(len >= 2 * MSC && len <= 2 * MSC + 5, 1'b1);
    bus(1'b1, `EIO_A_TIME, 32'h0000_0032);
    bus(1'b1, `EIO_A_COMMIT, 32'h0);
    done_len(50);
    chk(len >= MSC && len <= MSC + 5, 1'b1);
    // releasing edge
    bus(1'b1, `EIO_A_CTRL, 32'h2a);
    m = n_ms;
    u_ctrl.lvl(6, 1'b1);
    repeat (10) @(posedge clk_sys);
    chk(n_ms - m, 0);
    u_ctrl.lvl(6, 1'b0);
    repeat (8) @(posedge clk_sys);
    chk(n_ms - m, 1);
    // filter at 50 ms: short hold dropped, long hold passed
    bus(1'b1, `EIO_A_CTRL, 32'h26);
    m = n_ms;
    p = n_pr;
    u_ctrl.pulse(6, 50 * MSC - 100);
    repeat (10) @(posedge clk_sys);
    chk(n_ms - m, 0);
    u_ctrl.pulse(6, 50 * MSC + 100);
    repeat (10) @(posedge clk_sys);
    chk(n_ms - m, 1);
    u_ctrl.pulse(2, 50 * MSC + 100);
    repeat (10) @(posedge clk_sys);
    chk(n_pr - p, 1);
    // scanner routing with scan settings 0 to 2
    for (int s = 0; s < 3; s++)
    begin
      bus(1'b1, `EIO_A_CTRL, 32'h60 | (s << 7));
      bus(1'b0, `EIO_A_STAT, 32'h0);
      chk(rd[7], s != 0);
    end
    // test mode: inputs seen, outputs forced
    u_ctrl.lvl(0, 1'b1);
    u_ctrl.lvl(3, 1'b1);
    u_ctrl.lvl(4, 1'b1);
    bus(1'b1, `EIO_A_CTRL, 32'h220);
    bus(1'b1, `EIO_A_FJ, 32'h009a_5a5a);
    bus(1'b1, `EIO_A_FD, 32'h0001_2345);
    repeat (3) @(posedge clk_sys);
    chk(pins, {24'h9a5a5a, 21'h12345});
    bus(1'b0, `EIO_A_STAT, 32'h0);
    chk(rd[6:0], 7'h19);
    // every event kind has been seen by now; a write of ones clears them
    chk(rd[18:16], 3'h7);
    bus(1'b1, `EIO_A_STAT, 32'h0007_0000);
    bus(1'b0, `EIO_A_STAT, 32'h0);
    chk(rd[18:16], 3'h0);
    print_verdict();
  end
endmodule : eio_top_tb
`default_nettype wire
